// ===== rtl/scan_irq_pkg.sv
// Purpose: shared constants, register map and helpers for the rotation
//          scan interrupt and debug readback block
// Assumes: one 40 MHz clock, AXI4-Lite register access, 32-bit data
// Notes:
// Notes on behaviour
// RULE1 - software writes only the low two debug bits, with plain writes
// RULE2 - view 0 reads the last table address fetched by the sequencer
// RULE3 - view 1 reads timing state index plus sequencer bits Q7..Q0
// RULE4 - view 2 reads the present timing sequencer output word
// RULE5 - view 3 reads selected DAC register number and its value
// RULE6 - seven flags, each with its own enable, one shared interrupt
// RULE7 - interrupt only when flag, its enable and global enable are set
// RULE8 - flags are never cleared by hardware, only by software writes
// RULE9 - flag 0 set by the front-end output bit chosen by its selector
// RULE10 - flag 1 set on each rising edge of sequence stop
// RULE11 - flag 2 set when the timing sequencer starts a sequence
// RULE12 - flag 3 set when counter one hits a selected interval
// RULE13 - flag 4 set when counter two hits a selected interval
// RULE14 - flag 5 set on entering a state whose byte has Q6 set
// RULE15 - flag 6 set on entering a state whose byte has Q7 set
// RULE16 - interval flags have hysteresis, one set per level crossing
// RULE17 - next index is Q5..Q3, Q0 above S2, S1 when Q7, Q6 excluded
// RULE18 - entering a Q1 state increments counter one when enabled
// RULE19 - stop falling edge fetches base plus new index into output bits
// RULE20 - a byte with Q7 set computes the next state at once
// RULE21 - interval hit on first exact multiple reached from another level
package scan_irq_pkg;
  localparam int AXI_AW    = 8;
  localparam int MEM_AW    = 16;
  localparam int TSM_IDX_W = 5;
  localparam int TSM_OUT_W = 16;
  localparam int DAC_SEL_W = 3;
  localparam int DAC_VAL_W = 12;
  localparam int NUM_FLAGS = 7;

  // register byte offsets
  localparam logic [AXI_AW-1:0] OFF_DEBUG = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_COUNT = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_BASE  = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_CTRL  = 8'h0C;
  localparam logic [AXI_AW-1:0] OFF_FLAGS = 8'h10;
  localparam logic [AXI_AW-1:0] OFF_IE    = 8'h14;

  // control register fields
  localparam int CTL_EN     = 0;
  localparam int CTL_Q6EN   = 1;
  localparam int CTL_Q7EN   = 2;
  localparam int CTL_C1INC  = 3;
  localparam int CTL_C1DEC  = 4;
  localparam int CTL_C2EN   = 5;
  localparam int CTL_FESEL  = 8;
  localparam int CTL_IS1    = 12;
  localparam int CTL_IS2    = 14;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [6:0]  IE_RST   = 7'h00;

  // flag positions
  localparam int FLG_FE   = 0;
  localparam int FLG_STOP = 1;
  localparam int FLG_STRT = 2;
  localparam int FLG_CNT1 = 3;
  localparam int FLG_CNT2 = 4;
  localparam int FLG_Q6   = 5;
  localparam int FLG_Q7   = 6;

  // table byte bit positions
  localparam int Q1 = 1;
  localparam int Q2 = 2;
  localparam int Q6 = 6;
  localparam int Q7 = 7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    VIEW_ADDR = 2'b00,
    VIEW_TSM  = 2'b01,
    VIEW_OUT  = 2'b10,
    VIEW_DAC  = 2'b11
  } debug_view_e;

  // next state index from current byte and sensor pair
  function automatic logic [7:0] next_index(input logic [7:0] b,
      input logic q6_en, input logic q7_en, input logic s2, input logic s1);
    next_index = {b[7] & q6_en & q7_en, b[6] & q6_en, b[5:3], b[0], s2, s1};
  endfunction

  // low-bit mask of the selected counting interval: 4, 16, 64 or 256
  function automatic logic [7:0] interval_mask(input logic [1:0] sel);
    case (sel)
      2'b00:   interval_mask = 8'h03;
      2'b01:   interval_mask = 8'h0F;
      2'b10:   interval_mask = 8'h3F;
      default: interval_mask = 8'hFF;
    endcase
  endfunction
endpackage

// ===== rtl/interval_detector.sv
// Purpose: one-shot interval hit detector for an 8-bit event counter
// Assumes: value changes by at most one step per cycle
// Notes:   remembers the last multiple seen, so jitter around it is quiet
`timescale 1ns/1ps
module interval_detector
  import scan_irq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic [7:0] value,
  input  wire logic [1:0] sel,
  output logic            hit_q
);
  logic [7:0] level_q;
  logic       multiple;

  assign multiple = (value & interval_mask(sel)) == 8'h00;

  // RULE21 RULE16 fire only on a new level
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      level_q <= 8'h00;
      hit_q   <= 1'b0;
    end else begin
      hit_q <= multiple && (value != level_q);
      if (multiple) begin
        level_q <= value;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !enable);

  a_hyst_no_repeat: assert property (hit_q && $stable(value) |=> !hit_q) // RULE16
    else $error("interval hit repeated on same level");
endmodule // interval_detector

// ===== rtl/state_sequencer.sv
// Purpose: table-driven processing sequencer, fetches next state bytes
// Assumes: memory answers a held request with a one-cycle ack
// Notes:   byte and state clear while disabled, so first fetch is base+S2S1
`timescale 1ns/1ps
module state_sequencer
  import scan_irq_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              enable,
  input  wire logic              q6_en,
  input  wire logic              q7_en,
  input  wire logic              stop_fall,
  input  wire logic              s1,
  input  wire logic              s2,
  input  wire logic [MEM_AW-1:0] base,
  output logic                   mem_req_q,
  output logic [MEM_AW-1:0]      mem_addr_q,
  input  wire logic              mem_ack,
  input  wire logic [7:0]        mem_rdata,
  output logic [7:0]             byte_q,
  output logic                   entered_q
);
  typedef enum logic [0:0] {
    SEQ_IDLE  = 1'b0,
    SEQ_FETCH = 1'b1
  } seq_state_e;

  seq_state_e        state_q;
  logic [MEM_AW-1:0] next_addr;

  // RULE17 index above the table base
  assign next_addr = base +
      MEM_AW'({8'h00, next_index(byte_q, q6_en, q7_en, s2, s1)});

  // RULE19 RULE20 fetch on stop fall, or at once after a Q7 byte
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state_q    <= SEQ_IDLE;
      mem_req_q  <= 1'b0;
      mem_addr_q <= '0;
      byte_q     <= 8'h00;
      entered_q  <= 1'b0;
    end else begin
      entered_q <= 1'b0;
      case (state_q)
        SEQ_IDLE: begin
          if (stop_fall || byte_q[Q7]) begin
            mem_addr_q <= next_addr;
            mem_req_q  <= 1'b1;
            state_q    <= SEQ_FETCH;
          end
        end
        SEQ_FETCH: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            byte_q    <= mem_rdata;
            entered_q <= 1'b1;
            state_q   <= SEQ_IDLE;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !enable);

  sequence s_fetch_start;
    state_q == SEQ_IDLE && stop_fall;
  endsequence

  a_next_index_addr: assert property (s_fetch_start |=> // RULE17
      mem_req_q && mem_addr_q == $past(next_addr))
    else $error("fetch address not base plus next index");
  a_q7_immediate: assert property (entered_q && byte_q[Q7] |=> // RULE20
      mem_req_q)
    else $error("Q7 byte did not fetch at once");
  a_fetch_latch: assert property (mem_req_q && mem_ack |=> // RULE19
      entered_q && byte_q == $past(mem_rdata))
    else $error("fetched byte not latched");
endmodule // state_sequencer

// ===== rtl/rotation_scan_irq_debug.sv
// Purpose: interrupt flags, event counters and debug readback of the
//          rotation scan peripheral, AXI4-Lite register slave
// Assumes: all inputs synchronous to aclk, stop signal well below aclk
// Notes:   flags clear by writing ones; a set in the same cycle wins
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rotation_scan_irq_debug
  import scan_irq_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 global_interrupt_enable,
  input  wire logic [7:0]           front_end_output_bit,
  input  wire logic                 sequence_stop_signal,
  input  wire logic                 sequence_start,
  input  wire logic                 sensor_s1,
  input  wire logic                 sensor_s2,
  input  wire logic [TSM_IDX_W-1:0] tsm_state_index,
  input  wire logic [TSM_OUT_W-1:0] tsm_output_word,
  input  wire logic [DAC_SEL_W-1:0] dac_select,
  input  wire logic [DAC_VAL_W-1:0] dac_value,
  output logic                      mem_req,
  output logic [MEM_AW-1:0]         mem_addr,
  input  wire logic                 mem_ack,
  input  wire logic [7:0]           mem_rdata,
  output logic                      irq_q
);
  logic [AXI_AW-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                aw_held_q;
  logic                w_held_q;
  logic                wr_en;
  logic                ar_hs;
  debug_view_e         view_q;
  logic [15:0]         ctrl_q;
  logic [15:0]         base_q;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] ie_q;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [7:0]          cnt1_q;
  logic [7:0]          cnt2_q;
  logic                stop_q;
  logic                enable;
  logic [7:0]          state_byte;
  logic                entered;
  logic                hit1;
  logic                hit2;
  logic                inc1;
  logic                dec1;
  logic [31:0]         rd_word;
  logic                rd_hit;

  // merge a write into a register under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  assign enable = ctrl_q[CTL_EN];
  assign wr_en  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign ar_hs  = s_axi_arvalid && s_axi_arready;

  // write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_held_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_held_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // write response, slave error on unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      case (awaddr_q)
        OFF_DEBUG, OFF_COUNT, OFF_BASE, OFF_CTRL, OFF_FLAGS, OFF_IE:
          s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // RULE1 only the low two bits are kept, so wider writes are harmless
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      view_q <= VIEW_ADDR;
    end else if (wr_en && awaddr_q == OFF_DEBUG && wstrb_q[0]) begin
      view_q <= debug_view_e'(wdata_q[1:0]);
    end
  end

  // control, table base and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      base_q <= BASE_RST;
      ie_q   <= IE_RST;
    end else if (wr_en) begin
      if (awaddr_q == OFF_CTRL) begin
        ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == OFF_BASE) begin
        base_q <= merge16(base_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == OFF_IE && wstrb_q[0]) begin
        ie_q <= wdata_q[NUM_FLAGS-1:0];
      end
    end
  end

  // stop edge tracker
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= sequence_stop_signal;
    end
  end

  state_sequencer u_seq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (enable),
    .q6_en      (ctrl_q[CTL_Q6EN]),
    .q7_en      (ctrl_q[CTL_Q7EN]),
    .stop_fall  (stop_q && !sequence_stop_signal),
    .s1         (sensor_s1),
    .s2         (sensor_s2),
    .base       (base_q),
    .mem_req_q  (mem_req),
    .mem_addr_q (mem_addr),
    .mem_ack    (mem_ack),
    .mem_rdata  (mem_rdata),
    .byte_q     (state_byte),
    .entered_q  (entered)
  );

  // RULE18 up on Q1, down on Q2, both cancel
  assign inc1 = entered && state_byte[Q1] && ctrl_q[CTL_C1INC];
  assign dec1 = entered && state_byte[Q2] && ctrl_q[CTL_C1DEC];

  // event counters, held cleared while the block is disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      cnt1_q <= 8'h00;
      cnt2_q <= 8'h00;
    end else begin
      if (inc1 && !dec1) begin
        cnt1_q <= cnt1_q + 8'h01;
      end else if (dec1 && !inc1) begin
        cnt1_q <= cnt1_q - 8'h01;
      end
      if (entered && state_byte[Q2] && ctrl_q[CTL_C2EN]) begin
        cnt2_q <= cnt2_q - 8'h01;
      end
    end
  end

  // RULE12 counter one interval
  interval_detector u_det1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (enable),
    .value   (cnt1_q),
    .sel     (ctrl_q[CTL_IS1+:2]),
    .hit_q   (hit1)
  );

  // RULE13 counter two interval
  interval_detector u_det2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (enable),
    .value   (cnt2_q),
    .sel     (ctrl_q[CTL_IS2+:2]),
    .hit_q   (hit2)
  );

  // RULE6 RULE9 RULE10 RULE11 RULE14 RULE15 flag sources
  always_comb begin
    flag_set           = '0;
    flag_set[FLG_FE]   = front_end_output_bit[ctrl_q[CTL_FESEL+:3]];
    flag_set[FLG_STOP] = sequence_stop_signal && !stop_q;
    flag_set[FLG_STRT] = sequence_start;
    flag_set[FLG_CNT1] = hit1;
    flag_set[FLG_CNT2] = hit2;
    flag_set[FLG_Q6]   = entered && state_byte[Q6];
    flag_set[FLG_Q7]   = entered && state_byte[Q7];
  end

  // RULE8 cleared only by a write of ones, a new event wins the cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else if (wr_en && awaddr_q == OFF_FLAGS && wstrb_q[0]) begin
      flags_q <= (flags_q & ~wdata_q[NUM_FLAGS-1:0]) | flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  // RULE7 one shared request, gated by the global enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(flags_q & ie_q)) && global_interrupt_enable;
    end
  end

  // RULE2 RULE3 RULE4 RULE5 debug views and register readback
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      OFF_DEBUG: begin
        case (view_q)
          VIEW_ADDR: rd_word = {16'h0000, mem_addr};
          VIEW_TSM:  rd_word = {19'h0_0000, tsm_state_index, state_byte};
          VIEW_OUT:  rd_word = {16'h0000, tsm_output_word};
          default:   rd_word = {17'h0_0000, dac_select, dac_value};
        endcase
      end
      OFF_COUNT: rd_word = {16'h0000, cnt2_q, cnt1_q};
      OFF_BASE:  rd_word = {16'h0000, base_q};
      OFF_CTRL:  rd_word = {16'h0000, ctrl_q};
      OFF_FLAGS: rd_word = {25'h000_0000, flags_q};
      OFF_IE:    rd_word = {25'h000_0000, ie_q};
      default:   rd_hit  = 1'b0;
    endcase
  end

  // read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_debug_read(debug_view_e v);
    ar_hs && s_axi_araddr == OFF_DEBUG && view_q == v;
  endsequence

  a_view_addr: assert property (s_debug_read(VIEW_ADDR) |=> // RULE2
      s_axi_rvalid && s_axi_rdata[15:0] == $past(mem_addr))
    else $error("view 0 did not return last address");
  a_view_tsm: assert property (s_debug_read(VIEW_TSM) |=> // RULE3
      s_axi_rdata[7:0] == $past(state_byte) &&
      s_axi_rdata[12:8] == $past(tsm_state_index))
    else $error("view 1 wrong");
  a_view_out: assert property (s_debug_read(VIEW_OUT) |=> // RULE4
      s_axi_rdata[15:0] == $past(tsm_output_word))
    else $error("view 2 wrong");
  a_view_dac: assert property (s_debug_read(VIEW_DAC) |=> // RULE5
      s_axi_rdata[14:12] == $past(dac_select))
    else $error("view 3 wrong");
  a_irq_gated: assert property (!global_interrupt_enable |=> !irq_q) // RULE7
    else $error("interrupt without global enable");
  a_irq_raised: assert property (global_interrupt_enable && // RULE7
      (|(flags_q & ie_q)) |=> irq_q)
    else $error("enabled flag gave no interrupt");
  a_flag_no_selfclr: assert property (|($past(flags_q) & ~flags_q) |-> // RULE8
      $past(wr_en) && $past(awaddr_q) == OFF_FLAGS)
    else $error("flag cleared without a write");
  a_stop_rise_flag: assert property ($rose(sequence_stop_signal) // RULE10
      |=> flags_q[FLG_STOP])
    else $error("stop rise missed");
  a_start_flag: assert property (sequence_start |=> flags_q[FLG_STRT]) // RULE11
    else $error("sequence start missed");
  a_q6_state_flag: assert property (entered && state_byte[Q6] // RULE14
      |=> flags_q[FLG_Q6])
    else $error("Q6 state flag missed");
  a_q7_state_flag: assert property (entered && state_byte[Q7] // RULE15
      |=> flags_q[FLG_Q7])
    else $error("Q7 state flag missed");
  a_cnt1_inc: assert property (enable && inc1 && !dec1 |=> // RULE18
      cnt1_q == $past(cnt1_q) + 8'h01)
    else $error("counter one did not increment");
endmodule // rotation_scan_irq_debug

// ===== bench/table_mem_model.sv
// Purpose: table memory answering fetches of the state sequencer
// Assumes: one request at a time, held until ack
// Notes:   latency alternates, so prompt and slow answers both occur
`timescale 1ns/1ps
module table_mem_model
  import scan_irq_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              mem_req,
  input  wire logic [MEM_AW-1:0] mem_addr,
  output logic                   mem_ack,
  output logic [7:0]             mem_rdata
);
  logic [7:0] tbl [16];
  logic [1:0] wait_q;
  logic       slow_q;

  // answer a held request; data toggles when no answer is due,
  // so a sample taken one cycle after ack never looks valid
  always_ff @(posedge aclk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      wait_q    <= 2'h0;
      slow_q    <= 1'b0;
      mem_rdata <= 8'h5A;
    end else if (mem_req && !mem_ack) begin
      if (wait_q == {slow_q, 1'b0}) begin
        mem_ack   <= 1'b1;
        mem_rdata <= tbl[mem_addr[3:0]];
        wait_q    <= 2'h0;
        slow_q    <= ~slow_q;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule // table_mem_model

// ===== bench/rotation_scan_irq_debug_test.sv
// Purpose: register-level bench of the scan interrupt and debug block
// Assumes: AXI4-Lite master tasks, ready lines held high by the bench
// Notes:   table bytes are loaded straight into the memory model
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module rotation_scan_irq_debug_test
  import scan_irq_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, global_interrupt_enable;
  logic sequence_stop_signal, sequence_start, sensor_s1, sensor_s2;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_req, mem_ack, irq_q;
  logic [AXI_AW-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [7:0]           front_end_output_bit, mem_rdata;
  logic [TSM_IDX_W-1:0] tsm_state_index;
  logic [TSM_OUT_W-1:0] tsm_output_word;
  logic [DAC_SEL_W-1:0] dac_select;
  logic [DAC_VAL_W-1:0] dac_value;
  logic [MEM_AW-1:0]    mem_addr;
  int                   error_cnt = 0;
  int                   tests_run = 0;

  rotation_scan_irq_debug dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_interrupt_enable, .front_end_output_bit,
    .sequence_stop_signal, .sequence_start, .sensor_s1, .sensor_s2,
    .tsm_state_index, .tsm_output_word, .dac_select, .dac_value,
    .mem_req, .mem_addr, .mem_ack, .mem_rdata, .irq_q);
  table_mem_model mem (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata);

  // 25 ns clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic expired;
    error_cnt++;
    $display("[FAIL] wait expired");
    end_sim();
  endtask

  // write; bready stays high, so the answer is taken when it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (n >= 50) expired();
    `CHK("bresp", r, s_axi_bresp)
  endtask

  // read and compare data and response
  task automatic rck(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (n >= 50) expired();
    `CHK("rresp", r, s_axi_rresp)
    `CHK("rdata", e, s_axi_rdata)
  endtask

  // one timing sequence: stop rises, sensors settle, stop falls
  task automatic step(input logic [1:0] s);
    int n;
    n = 0;
    {sensor_s2, sensor_s1} <= s;
    sequence_stop_signal   <= 1'b1;
    repeat (16) @(posedge aclk);
    sequence_stop_signal <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!mem_ack && n < 40);
    if (n >= 40) expired();
    repeat (16) @(posedge aclk);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {global_interrupt_enable, sequence_stop_signal} = 2'h0;
    {sequence_start, sensor_s1, sensor_s2} = 3'h0;
    front_end_output_bit = 8'h00;
    tsm_state_index = 5'h15;
    tsm_output_word = 16'hA5C3;
    dac_select = 3'h6;
    dac_value = 12'h9E1;
    mem.tbl = '{8'h88, 8'h40, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
                8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, unmapped place, debug views
    rck(OFF_IE, 32'h0000_0000, RESP_OKAY);
    rck(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    rck(8'h18, 32'h0000_0000, RESP_SLVERR);
    wr(8'h18, 32'h0000_00FF, RESP_SLVERR);
    wr(OFF_DEBUG, 32'h0000_0001, RESP_OKAY);
    rck(OFF_DEBUG, 32'h0000_1500, RESP_OKAY);
    wr(OFF_DEBUG, 32'h0000_0002, RESP_OKAY);
    rck(OFF_DEBUG, 32'h0000_A5C3, RESP_OKAY);
    wr(OFF_DEBUG, 32'h0000_0003, RESP_OKAY);
    rck(OFF_DEBUG, 32'h0000_69E1, RESP_OKAY);
    // front-end bit 3, stop rise and start pulse raise flags 0..2
    wr(OFF_IE, 32'h0000_007F, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0301, RESP_OKAY);
    front_end_output_bit <= 8'h08;
    repeat (3) @(posedge aclk);
    front_end_output_bit <= 8'h00;
    step(2'h3);
    sequence_start <= 1'b1;
    @(posedge aclk);
    sequence_start <= 1'b0;
    rck(OFF_FLAGS, 32'h0000_0007, RESP_OKAY);
    rck(OFF_FLAGS, 32'h0000_0007, RESP_OKAY);
    `CHK("irq", 1'b0, irq_q)
    global_interrupt_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("irq", 1'b1, irq_q)
    wr(OFF_IE, 32'h0000_0000, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("irq", 1'b0, irq_q)
    wr(OFF_IE, 32'h0000_007F, RESP_OKAY);
    wr(OFF_FLAGS, 32'h0000_0007, RESP_OKAY);
    rck(OFF_FLAGS, 32'h0000_0000, RESP_OKAY);
    `CHK("irq", 1'b0, irq_q)
    // counting sequence: base 0x120, counter one up/down, interval 4
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_BASE, 32'h0000_0120, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0019, RESP_OKAY);
    repeat (4) step(2'h3);
    rck(OFF_COUNT, 32'h0000_0004, RESP_OKAY);
    wr(OFF_DEBUG, 32'h0000_0000, RESP_OKAY);
    rck(OFF_DEBUG, 32'h0000_0123, RESP_OKAY);
    rck(OFF_FLAGS, 32'h0000_000A, RESP_OKAY);
    wr(OFF_FLAGS, 32'h0000_007F, RESP_OKAY);
    // back across the level and up again: no second interval flag
    step(2'h2);
    step(2'h3);
    rck(OFF_COUNT, 32'h0000_0004, RESP_OKAY);
    rck(OFF_FLAGS, 32'h0000_0002, RESP_OKAY);
    wr(OFF_DEBUG, 32'h0000_0001, RESP_OKAY);
    rck(OFF_DEBUG, 32'h0000_1502, RESP_OKAY);
    // Q6 state, then Q7 state chaining at once to index 8
    step(2'h1);
    step(2'h0);
    rck(OFF_FLAGS, 32'h0000_0062, RESP_OKAY);
    wr(OFF_DEBUG, 32'h0000_0000, RESP_OKAY);
    rck(OFF_DEBUG, 32'h0000_0128, RESP_OKAY);
    rck(OFF_COUNT, 32'h0000_0005, RESP_OKAY);
    // counter two down to a level, then the Q6 index bit in use
    wr(OFF_CTRL, 32'h0000_0023, RESP_OKAY);
    repeat (4) step(2'h2);
    rck(OFF_COUNT, 32'h0000_FC05, RESP_OKAY);
    rck(OFF_FLAGS, 32'h0000_0072, RESP_OKAY);
    step(2'h1);
    step(2'h3);
    rck(OFF_DEBUG, 32'h0000_0163, RESP_OKAY);
    end_sim();
  end
endmodule // rotation_scan_irq_debug_test
